// >>> rtl/fl_pkg.sv
/*
  Package for the serial flash identification / mode / suspend command block.
  Assumes a single 250 MHz core clock that oversamples the serial pins.
*/
package fl_pkg;
  // ----------------------------------------------------------------
  // Opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_MAKER_DEV_ID = 8'h90;
  localparam logic [7:0] OP_IDENT_READ = 8'h9F;
  localparam logic [7:0] OP_HIGH_PERF = 8'hA3;
  localparam logic [7:0] OP_RELEASE = 8'hAB;
  localparam logic [7:0] OP_POWER_DOWN = 8'hB9;
  localparam logic [7:0] OP_CONT_EXIT = 8'hFF;
  localparam logic [7:0] OP_UNIQUE_ID = 8'h4B;
  localparam logic [7:0] OP_SUSPEND = 8'h75;
  localparam logic [7:0] OP_RESUME = 8'h7A;
  localparam logic [3:0] CONT_MODE_NIBBLE = 4'hA;
  localparam logic [7:0] ADDR_DEV_FIRST = 8'h01;
  // ----------------------------------------------------------------
  // Identification values (arbitrary, not any real part)
  // ----------------------------------------------------------------
  localparam logic [7:0] MAKER_ID = 8'h5A;
  localparam logic [7:0] DEVICE_ID = 8'h14;
  localparam logic [7:0] MEM_TYPE_ID = 8'h40;
  localparam logic [7:0] CAPACITY_ID = 8'h15;
  localparam logic [127:0] UNIQUE_ID = 128'h0123_4567_89AB_CDEF_FEDC_BA98_7654_3210;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 4;
  localparam int T_SUSPEND_NS = 1000;
  localparam int T_RESUME_NS = 200;
  localparam logic [9:0] SUSPEND_CYC = 10'(T_SUSPEND_NS / CLK_PERIOD_NS);
  localparam logic [7:0] RESUME_CYC = 8'(T_RESUME_NS / CLK_PERIOD_NS);
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {ST_OPCODE, ST_ADDR, ST_OUT, ST_SKIP} fl_state_type;
  typedef struct packed {
    logic valid;
    logic refused;
    logic [7:0] opcode;
  } fl_cmd_type;
endpackage

// >>> rtl/fl_uid_rom.sv
/*
  Small read-only store for the 128-bit unique number, byte addressed.
  Read data are registered; address settles well before the byte is used.
*/
`timescale 1ns/100ps
`default_nettype none
module fl_uid_rom (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Read port
  input wire logic [3:0] addr,
  output logic [7:0] data
);
  import fl_pkg::*;

  // First byte out is the most significant one
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      data <= 8'h00;
    end else begin
      data <= 8'(UNIQUE_ID >> {4'(4'hF - addr), 3'h0});
    end
  end
endmodule
`default_nettype wire

// >>> rtl/fl_cmd.sv
/*
  Command handling for identification reads, high performance mode,
  continuous read exit, unique number read and program/erase suspend/resume.
  Assumes serial pins are asynchronous to mclk and the serial clock is
  several mclk periods long; the array engine is outside.
*/
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - 90H zero address gives maker, device
// - Address one puts device byte first
// - 9FH returns maker, type, capacity bytes
// - 24 identification bits out on falling edges
// - 9FH not decoded while cycle busy
// - Chip select high ends identification output
// - A3H plus three dummies enters high performance
// - ABH when not busy, or B9H, leaves high performance
// - AXH mode bits make reads opcode-less
// - AXH ignores commands; FFH exits it
// - 4BH, address, dummy, then 128-bit number
// - Suspend only when idle-suspend and busy
// - Suspend sets flag, busy clears within latency
// - Writes, erases, programs refused while suspended
// - Other array reads allowed while suspended
// - Power-up clears suspended state
// - Resume only when suspended and not busy
// - Resume clears flag, sets busy within 200ns
// - Busy flag tracks self-timed cycle
module fl_cmd (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Serial pins
  input wire logic cs_n_pin,
  input wire logic sclk_pin,
  input wire logic si_pin,
  output logic so,
  output logic so_oe,
  // Array engine
  input wire logic pe_start,
  input wire logic pe_suspendable,
  input wire logic pe_done,
  output logic pe_suspend,
  output logic pe_resume,
  // Continuous read mode bits from the fast read engine
  input wire logic cont_read_set,
  input wire logic [7:0] cont_read_mode_bits,
  output logic cont_read_start,
  // Status and forwarded commands
  output logic write_busy_flag,
  output logic suspended_flag,
  output logic high_perf_mode,
  output logic cont_read_active,
  output fl_pkg::fl_cmd_type cmd_out
);
  import fl_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisers and edge detect
  // ----------------------------------------------------------------
  logic [1:0] cs_meta, sclk_meta, si_meta;
  logic cs_s, sclk_s, si_s, cs_d, sclk_d;
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      cs_meta <= 2'h3;
      sclk_meta <= 2'h0;
      si_meta <= 2'h0;
      cs_d <= 1'b1;
      sclk_d <= 1'b0;
    end else begin
      cs_meta <= {cs_meta[0], cs_n_pin};
      sclk_meta <= {sclk_meta[0], sclk_pin};
      si_meta <= {si_meta[0], si_pin};
      cs_d <= cs_s;
      sclk_d <= sclk_s;
    end
  end
  assign cs_s = cs_meta[1];
  assign sclk_s = sclk_meta[1];
  assign si_s = si_meta[1];
  logic rise, fall, cs_end;
  assign rise = ~cs_s & sclk_s & ~sclk_d;
  assign fall = ~cs_s & ~sclk_s & sclk_d;
  assign cs_end = cs_s & ~cs_d;
  function automatic logic is_locked(input logic [7:0] op);
    case (op)
      8'h01, 8'h31, 8'h11, 8'h44, 8'h42, 8'h20, 8'h52, 8'hD8, 8'hC7, 8'h60, 8'h02, 8'h32:
        is_locked = 1'b1;
      default: is_locked = 1'b0;
    endcase
  endfunction
  // ----------------------------------------------------------------
  // Input framing and decode
  // ----------------------------------------------------------------
  fl_state_type state;
  logic [6:0] shin;
  logic [2:0] bit_cnt, byte_cnt;
  logic [7:0] cur_op;
  logic op_seen, addr_hi_zero, dev_first;
  logic byte_done;
  logic [7:0] in_byte;
  assign byte_done = rise & (bit_cnt == 3'h7);
  assign in_byte = {shin, si_s};
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= ST_OPCODE;
      shin <= 7'h00;
      bit_cnt <= 3'h0;
      byte_cnt <= 3'h0;
      cur_op <= 8'h00;
      op_seen <= 1'b0;
      addr_hi_zero <= 1'b0;
      dev_first <= 1'b0;
    end else if (cs_s) begin
      state <= ST_OPCODE;
      bit_cnt <= 3'h0;
      byte_cnt <= 3'h0;
      op_seen <= 1'b0;
    end else if (rise) begin
      shin <= in_byte[6:0];
      bit_cnt <= bit_cnt + 3'h1;
      if (byte_done) begin
        if (state != ST_OPCODE && byte_cnt != 3'h7) begin
          byte_cnt <= byte_cnt + 3'h1;
        end
        unique case (state)
          ST_OPCODE: begin
            cur_op <= in_byte;
            addr_hi_zero <= 1'b1;
            if (cont_read_active) begin
              state <= ST_SKIP;
            end else begin
              op_seen <= 1'b1;
              if (in_byte == OP_MAKER_DEV_ID || in_byte == OP_UNIQUE_ID
                  || in_byte == OP_HIGH_PERF) begin
                state <= ST_ADDR;
              end else if (in_byte == OP_IDENT_READ && !write_busy_flag) begin
                state <= ST_OUT;
              end else begin
                state <= ST_SKIP;
              end
            end
          end
          ST_ADDR: begin
            if (byte_cnt < 3'h2 && in_byte != 8'h00) begin
              addr_hi_zero <= 1'b0;
            end
            if (cur_op == OP_MAKER_DEV_ID && byte_cnt == 3'h2) begin
              dev_first <= addr_hi_zero && in_byte == ADDR_DEV_FIRST;
              state <= ST_OUT;
            end else if (cur_op == OP_UNIQUE_ID && byte_cnt == 3'h3) begin
              state <= ST_OUT;
            end
          end
          ST_OUT, ST_SKIP: begin
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Output shifter
  // ----------------------------------------------------------------
  logic [3:0] out_idx;
  logic [2:0] out_bit;
  logic [6:0] sh_out;
  logic [7:0] sel, rom_data;
  fl_uid_rom u_rom (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .addr(out_idx),
    .data(rom_data)
  );
  always_comb begin
    sel = rom_data;
    if (cur_op == OP_IDENT_READ) begin
      unique case (out_idx[1:0])
        2'h0: sel = MAKER_ID;
        2'h1: sel = MEM_TYPE_ID;
        default: sel = CAPACITY_ID;
      endcase
    end else if (cur_op == OP_MAKER_DEV_ID) begin
      sel = (dev_first ^ out_idx[0]) ? DEVICE_ID : MAKER_ID;
    end
  end
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      so <= 1'b0;
      so_oe <= 1'b0;
      out_idx <= 4'h0;
      out_bit <= 3'h0;
      sh_out <= 7'h00;
    end else if (cs_s) begin
      so_oe <= 1'b0;
      so <= 1'b0;
      out_idx <= 4'h0;
      out_bit <= 3'h0;
    end else if (fall && state == ST_OUT) begin
      so_oe <= 1'b1;
      out_bit <= out_bit + 3'h1;
      if (out_bit == 3'h0) begin
        so <= sel[7];
        sh_out <= sel[6:0];
        if (cur_op == OP_IDENT_READ && out_idx == 4'h2) begin
          out_idx <= 4'h0;
        end else begin
          out_idx <= out_idx + 4'h1;
        end
      end else begin
        so <= sh_out[6];
        sh_out <= {sh_out[5:0], 1'b0};
      end
    end
  end

  // ----------------------------------------------------------------
  // Modes and status flags
  // ----------------------------------------------------------------
  logic exact8, acc_sus, acc_res;
  logic suspendable;
  logic [9:0] sus_timer;
  assign exact8 = cs_end & op_seen & byte_cnt == 3'h0 & bit_cnt == 3'h0;
  assign acc_sus = exact8 && cur_op == OP_SUSPEND && !suspended_flag
                   && write_busy_flag && suspendable;
  assign acc_res = exact8 && cur_op == OP_RESUME && suspended_flag
                   && !write_busy_flag;
  // Reset is power-up, so no suspend survives it
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      suspended_flag <= 1'b0;
      write_busy_flag <= 1'b0;
      suspendable <= 1'b0;
      sus_timer <= 10'h000;
      pe_suspend <= 1'b0;
      pe_resume <= 1'b0;
    end else begin
      pe_suspend <= acc_sus;
      pe_resume <= acc_res;
      if (sus_timer != 10'h000) begin
        sus_timer <= sus_timer - 10'h001;
      end
      if (pe_done && !suspended_flag) begin
        write_busy_flag <= 1'b0;
      end
      if (sus_timer == 10'h001) begin
        write_busy_flag <= 1'b0;
      end
      if (acc_sus) begin
        suspended_flag <= 1'b1;
        sus_timer <= SUSPEND_CYC;
      end
      if (acc_res) begin
        suspended_flag <= 1'b0;
        write_busy_flag <= 1'b1;
      end
      if (pe_start) begin
        write_busy_flag <= 1'b1;
        suspendable <= pe_suspendable;
      end
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      high_perf_mode <= 1'b0;
      cont_read_active <= 1'b0;
      cont_read_start <= 1'b0;
    end else begin
      cont_read_start <= byte_done && state == ST_OPCODE && cont_read_active
                         && in_byte != OP_CONT_EXIT;
      if (cs_end && op_seen && cur_op == OP_HIGH_PERF && byte_cnt == 3'h3
          && bit_cnt == 3'h0) begin
        high_perf_mode <= 1'b1;
      end
      if (exact8 && (cur_op == OP_POWER_DOWN
                     || (cur_op == OP_RELEASE && !write_busy_flag))) begin
        high_perf_mode <= 1'b0;
      end
      if (byte_done && state == ST_OPCODE && cont_read_active
          && in_byte == OP_CONT_EXIT) begin
        cont_read_active <= 1'b0;
      end
      if (cont_read_set) begin
        cont_read_active <= cont_read_mode_bits[7:4] == CONT_MODE_NIBBLE;
      end
    end
  end

  // All opcodes outside continuous read go to the array engine; suspended writes are refused
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      cmd_out <= '0;
    end else begin
      cmd_out.valid <= byte_done && state == ST_OPCODE && !cont_read_active;
      if (byte_done && state == ST_OPCODE) begin
        cmd_out.opcode <= in_byte;
        cmd_out.refused <= (suspended_flag && is_locked(in_byte))
                           || (in_byte == OP_IDENT_READ && write_busy_flag);
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  localparam int SUS_BOUND = 251;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  sus_set_a: assert property (acc_sus |=> suspended_flag && pe_suspend)
    else $error("suspend not flagged");
  busy_clear_a: assert property ($rose(suspended_flag) |-> ##[1:SUS_BOUND] !write_busy_flag)
    else $error("busy not cleared after suspend");
  sus_ignore_a: assert property (exact8 && cur_op == OP_SUSPEND && !write_busy_flag
      |=> !suspended_flag || $past(suspended_flag)) else $error("suspend taken when idle");
  res_ignore_a: assert property (exact8 && cur_op == OP_RESUME && !suspended_flag
      |=> !pe_resume) else $error("resume taken without suspend");
  resume_a: assert property (acc_res |=> !suspended_flag ##[0:49] write_busy_flag)
    else $error("resume flags wrong");
  id_busy_a: assert property (byte_done && state == ST_OPCODE && !cont_read_active
      && in_byte == OP_IDENT_READ && write_busy_flag |=> state == ST_SKIP)
    else $error("ident read decoded while busy");
  cs_stop_a: assert property (cs_s |=> !so_oe && state == ST_OPCODE)
    else $error("output not stopped by deselect");
  lock_a: assert property (cmd_out.valid && suspended_flag && $past(suspended_flag)
      && is_locked(cmd_out.opcode) |-> cmd_out.refused) else $error("locked opcode passed");
  cont_ign_a: assert property (cont_read_active && byte_done && state == ST_OPCODE
      |=> !cmd_out.valid) else $error("command decoded in continuous mode");
  hpm_exit_a: assert property (exact8 && cur_op == OP_POWER_DOWN |=> !high_perf_mode)
    else $error("high performance mode kept");
  ident_c: cover property (state == ST_OUT && cur_op == OP_IDENT_READ ##1 fall);
  sus_res_c: cover property (acc_res ##1 !suspended_flag && write_busy_flag);
  uid_c: cover property (state == ST_OUT && cur_op == OP_UNIQUE_ID && out_idx == 4'hF);
endmodule
`default_nettype wire

// >>> sim/fl_host.sv
/*
  Serial host controller model that drives the flash command block's pins.
  Assumes a 32 ns serial clock, mode 0, called from the bench.
*/
`timescale 1ns/100ps
`default_nettype none
module fl_host (
  // Serial pins
  output logic cs_n_pin,
  output logic sclk_pin,
  output logic si_pin,
  input wire logic so
);
  initial begin
    cs_n_pin = 1'b1;
    sclk_pin = 1'b0;
    si_pin = 1'b0;
  end
  // ----------------------------------------------------------------
  // One frame: ntx bits out MSB first, then nrx bits back
  // ----------------------------------------------------------------
  // The bench sends identification reads after B9H with no ABH first; the block keeps no deep power-down state
  // Fast I/O is never issued here, so no mode switch precedes it
  task automatic frame(input logic [39:0] tx, input int ntx, input int nrx,
                       output logic [127:0] rx);
    rx = '0;
    #1.5 cs_n_pin = 1'b0;
    #16;
    for (int i = ntx - 1; i >= 0; i--) begin
      si_pin = tx[i];
      #16 sclk_pin = 1'b1;
      #16 sclk_pin = 1'b0;
    end
    for (int i = 0; i < nrx; i++) begin
      si_pin = ~si_pin;
      #16 sclk_pin = 1'b1;
      // Sampled late in the high half, well after the device updated so
      #16 rx = {rx[126:0], so};
      sclk_pin = 1'b0;
    end
    #16 cs_n_pin = 1'b1;
    // Released line shows no stale value
    si_pin = ~si_pin;
    #40;
  endtask
endmodule
`default_nettype wire

// >>> sim/testbench.sv
/*
  Self-checking bench for the flash command block.
  Assumes the host model fl_host and the package fl_pkg.
*/
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import fl_pkg::*;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic pe_start = 1'b0, pe_suspendable = 1'b0, pe_done = 1'b0;
  logic cont_read_set = 1'b0;
  logic [7:0] cont_read_mode_bits = 8'h00;
  wire cs_n_pin, sclk_pin, si_pin;
  logic so, so_oe, pe_suspend, pe_resume, cont_read_start;
  logic write_busy_flag, suspended_flag, high_perf_mode, cont_read_active;
  fl_cmd_type cmd_out;
  logic [127:0] rx;
  int fails = 0, n_compared = 0, n_sus = 0, n_res = 0, n_start = 0;
  int n_valid = 0, n_oe = 0, k;
  logic [7:0] wr_ops [12] = '{8'h01, 8'h31, 8'h11, 8'h44, 8'h42, 8'h20, 8'h52,
                              8'hD8, 8'hC7, 8'h60, 8'h02, 8'h32};
  always #2 mclk = ~mclk;
  fl_cmd u_fl_cmd (.mclk(mclk), .sys_rst(sys_rst), .cs_n_pin(cs_n_pin),
    .sclk_pin(sclk_pin), .si_pin(si_pin), .so(so), .so_oe(so_oe),
    .pe_start(pe_start), .pe_suspendable(pe_suspendable), .pe_done(pe_done),
    .pe_suspend(pe_suspend), .pe_resume(pe_resume), .cont_read_set(cont_read_set),
    .cont_read_mode_bits(cont_read_mode_bits), .cont_read_start(cont_read_start),
    .write_busy_flag(write_busy_flag), .suspended_flag(suspended_flag),
    .high_perf_mode(high_perf_mode), .cont_read_active(cont_read_active),
    .cmd_out(cmd_out));
  // An undriven output line reads back inverted, so stale data cannot pass
  fl_host u_fl_host (.cs_n_pin(cs_n_pin), .sclk_pin(sclk_pin), .si_pin(si_pin),
    .so(so_oe ? so : ~so));
  // Pulse and output-enable monitors
  always @(posedge mclk) begin
    n_sus <= n_sus + int'(pe_suspend === 1'b1);
    n_res <= n_res + int'(pe_resume === 1'b1);
    n_start <= n_start + int'(cont_read_start === 1'b1);
    n_valid <= n_valid + int'(cmd_out.valid === 1'b1);
    n_oe <= n_oe + int'(so_oe === 1'b1);
  end
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("Error t=%0t got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic op(input logic [7:0] c);
    u_fl_host.frame({32'h0, c}, 8, 0, rx);
    repeat (4) @(negedge mclk);
  endtask
  task automatic pulse(ref logic s);
    @(negedge mclk) s = 1'b1;
    @(negedge mclk) s = 1'b0;
    repeat (2) @(negedge mclk);
  endtask
  task automatic close_out();
    if (fails == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    #100000;
    fails++;
    close_out();
  end
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    repeat (6) @(negedge mclk);
    sys_rst = 1'b0;
    repeat (4) @(negedge mclk);
    chk({write_busy_flag, suspended_flag, high_perf_mode}, 0);
    u_fl_host.frame({8'h0, 8'h90, 24'h0}, 32, 32, rx);
    chk(rx[31:0], {MAKER_ID, DEVICE_ID, MAKER_ID, DEVICE_ID});
    u_fl_host.frame({8'h0, 8'h90, 24'h1}, 32, 16, rx);
    chk(rx[15:0], {DEVICE_ID, MAKER_ID});
    u_fl_host.frame({32'h0, 8'h9F}, 8, 32, rx);
    chk(rx[31:0], {MAKER_ID, MEM_TYPE_ID, CAPACITY_ID, MAKER_ID});
    u_fl_host.frame({32'h0, 8'h9F}, 8, 12, rx);
    chk(so_oe, 0);
    chk(rx[11:0], {MAKER_ID, MEM_TYPE_ID[7:4]});
    u_fl_host.frame({8'h4B, 32'h0}, 40, 128, rx);
    chk(rx, UNIQUE_ID);
    for (k = 0; k < 2; k++) begin
      u_fl_host.frame({8'h0, 8'hA3, 24'h0}, 32, 0, rx);
      chk(high_perf_mode, 1);
      op(k == 0 ? OP_RELEASE : OP_POWER_DOWN);
      chk(high_perf_mode, 0);
    end
    cont_read_mode_bits = 8'hA5;
    pulse(cont_read_set);
    chk(cont_read_active, 1);
    k = n_valid + n_oe;
    u_fl_host.frame({32'h0, 8'h9F}, 8, 16, rx);
    chk(n_valid + n_oe, k);
    chk(n_start, 1);
    op(OP_CONT_EXIT);
    chk(cont_read_active, 0);
    op(OP_RESUME);
    chk({suspended_flag, n_res}, 0);
    op(OP_SUSPEND);
    chk({suspended_flag, n_sus}, 0);
    pe_suspendable = 1'b1;
    pulse(pe_start);
    chk(write_busy_flag, 1);
    k = n_oe;
    u_fl_host.frame({32'h0, 8'h9F}, 8, 24, rx);
    chk({n_oe, cmd_out.refused}, {k, 1'b1});
    chk(write_busy_flag, 1);
    op(OP_SUSPEND);
    chk({suspended_flag, n_sus}, {1'b1, 32'd1});
    op(OP_RESUME);
    chk({suspended_flag, n_res}, {1'b1, 32'd0});
    repeat (260) @(negedge mclk);
    chk(write_busy_flag, 0);
    op(OP_SUSPEND);
    chk(n_sus, 1);
    foreach (wr_ops[i]) begin
      op(wr_ops[i]);
      chk({cmd_out.opcode, cmd_out.refused}, {wr_ops[i], 1'b1});
    end
    op(8'h03);
    chk(cmd_out.refused, 0);
    op(OP_RESUME);
    chk({suspended_flag, write_busy_flag, n_res}, {2'b01, 32'd1});
    pulse(pe_done);
    chk(write_busy_flag, 0);
    pe_suspendable = 1'b0;
    pulse(pe_start);
    op(OP_SUSPEND);
    chk({suspended_flag, n_sus}, {1'b0, 32'd1});
    pulse(pe_done);
    pe_suspendable = 1'b1;
    pulse(pe_start);
    op(OP_SUSPEND);
    chk(suspended_flag, 1);
    pulse(sys_rst);
    chk({suspended_flag, write_busy_flag}, 0);
    close_out();
  end
endmodule
`default_nettype wire
